// File: design/can_bt_consts.svh
// Constants for the CAN bit timing block: register indices, field
// positions, reset values and fixed timing figures.
// Assumes inclusion by its bare name from design sources only.
`ifndef CAN_BT_CONSTS_SVH
`define CAN_BT_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_CFG3 8'h28
`define IDX_CFG2 8'h29
`define IDX_CFG1 8'h2A
`define IDX_STAT 8'h2B
`define ADDR_SHIFT 2

// Timing configuration register 1 fields
`define CFG1_BRP_LSB 0
`define CFG1_BRP_MSB 5
`define CFG1_SJW_LSB 6
`define CFG1_SJW_MSB 7
// Timing configuration register 2 fields
`define CFG2_PROP_LSB 0
`define CFG2_PROP_MSB 2
`define CFG2_PS1_LSB 3
`define CFG2_PS1_MSB 5
`define CFG2_SAM_BIT 6
`define CFG2_SEL_BIT 7
// Timing configuration register 3 field
`define CFG3_PS2_LSB 0
`define CFG3_PS2_MSB 2

// Reset values
`define CFG1_RST 8'h00
`define CFG2_RST 8'h00
`define CFG3_RST 3'h0

// Processing time after the sample point, in quanta
`define PROC_TIME_TQ 4'h2
// One quantum, used for field value plus one decoding
`define ONE_TQ 4'h1
`define ONE_E 5'h01

`endif

// File: design/can_bt_pkg.sv
// Types shared by the CAN bit timing block and its quantum divider.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package can_bt_pkg;

   // Segment of the current bit time
   typedef enum logic [1:0] {
      SEG_SYNC,
      SEG_PROP,
      SEG_PH1,
      SEG_PH2
   } seg_t;

   // Whole state of the bit timing core
   typedef struct packed {
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [2:0] cfg3;
      seg_t seg;
      logic [3:0] qcnt;
      logic [2:0] ext;
      logic [2:0] shorten;
      logic synced;
      logic rx_meta;
      logic rx_q;
      logic rx_prev;
      logic samp_a;
      logic samp_b;
      logic rx_bit;
      logic bit_valid;
      logic bit_start;
      logic hard_sync;
      logic resync;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bt_state_t;

   // Whole state of the quantum divider
   typedef struct packed {
      logic [6:0] cnt;
      logic tq_tick;
      logic half_tick;
   } div_state_t;

endpackage

`default_nettype wire

// File: design/tq_if.sv
// Link between the bit timing core and its quantum divider.
// Assumes both ends run on the same pclk.
`default_nettype none

interface tq_if;
   logic tq_tick;
   logic half_tick;
   logic restart;
   logic [5:0] prescale;

   modport timer (input tq_tick, input half_tick,
                  output restart, output prescale);
   modport divider (output tq_tick, output half_tick,
                    input restart, input prescale);
endinterface

`default_nettype wire

// File: design/tq_divider.sv
// Quantum divider: one quantum is 2 x (prescale + 1) pclk cycles.
// Assumes prescale is stable while a bit is in progress.
`default_nettype none
`include "can_bt_consts.svh"

module tq_divider
   import can_bt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   tq_if.divider q
);

   div_state_t r, s;
   logic [6:0] last;
   logic [6:0] half;

   // Half point and end of one quantum in pclk cycles
   assign half = {1'b0, q.prescale};
   assign last = {q.prescale, 1'b1};

   // Count quanta; a restart realigns the quantum to the sync edge
   always_comb begin
      s = r;
      s.tq_tick = 1'b0;
      s.half_tick = 1'b0;
      if (q.restart) begin
         s.cnt = 7'h00;
      end else if (r.cnt >= last) begin
         s.cnt = 7'h00;
         s.tq_tick = 1'b1;  // [R7] [R21]
      end else begin
         s.cnt = r.cnt + 7'h01;
         s.half_tick = (r.cnt == half);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= s;
      end
   end

   assign q.tq_tick = r.tq_tick;
   assign q.half_tick = r.half_tick;

endmodule

`default_nettype wire

// File: design/can_bit_timing_sync.sv
// CAN bit timing and synchronisation: quantum prescaler, bit segments,
// sample point with optional triple sampling, hard and resync.
// Assumes an APB master on pclk, rx_line from the transceiver pin,
// and bus_idle / tx_active from frame logic on the same clock.
//
// Operation
// R1 - Each bit begins with a sync segment of exactly one quantum.
// R2 - Propagation segment is programmable from one to eight quanta.
// R3 - First phase one to eight quanta, second phase two to eight.
// R4 - Line level is read at the end of the first phase segment.
// R5 - Triple sampling adds two half-quantum earlier samples, majority decides.
// R6 - Processing takes two quanta from the sample point; second phase never shorter.
// R7 - Quantum comes from an oscillator prescaler, base of two periods.
// R8 - Falling edge on an idle bus restarts the bit at the sync segment.
// R9 - No resynchronisation in a bit after a hard synchronisation.
// R10 - Phase error is zero, positive before sample, negative after it.
// R11 - Error within jump width realigns the bit like a hard sync.
// R12 - Large positive error lengthens first phase by the jump width.
// R13 - Large negative error shortens second phase by the jump width.
// R14 - Jump width is one to four quanta and bounds every adjustment.
// R15 - Only recessive-to-dominant edges are used for synchronisation.
// R16 - At most one synchronisation per bit time.
// R17 - Edge used only if the last sampled value was recessive.
// R18 - While transmitting, no resync on positive phase error.
// R19 - Software keeps prop plus phase one above phase two and delay.
// R20 - Bit time is the sum of the four non-overlapping segments.
// R21 - Quantum is two times prescaler field plus one oscillator periods.
// R22 - Jump width field 00 means one quantum, 11 means four.
// R23 - Select clear: second phase is max of first phase and two.
// R24 - Sampled bit goes to frame logic with a one-cycle valid strobe.
// R25 - Segment adjustments last one bit, nominal lengths restored after.
//
// Design decisions made here: the address map and the APB slave port.
`default_nettype none
`include "can_bt_consts.svh"

module can_bit_timing_sync
   import can_bt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   input wire logic bus_idle,
   input wire logic tx_active,
   output logic rx_bit,
   output logic bit_valid,
   output logic bit_start,
   output logic hard_sync,
   output logic resync
);

   bt_state_t r, s;
   tq_if q ();

   // Field value plus one, used by the prop and phase segment lengths
   function automatic logic [3:0] plus_one(input logic [2:0] v);
      plus_one = {1'b0, v} + `ONE_TQ;
   endfunction

   // Register index from a byte address
   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[`ADDR_SHIFT+7:`ADDR_SHIFT];
   endfunction

   // Two out of three vote
   function automatic logic vote(input logic a, input logic b,
                                 input logic c);
      vote = (a & b) | (a & c) | (b & c);
   endfunction

   // Decoded configuration
   logic [3:0] prop_len;
   logic [3:0] ps1_nom;
   logic [3:0] ps1_len;
   logic [3:0] ps2_nom;
   logic [3:0] ps2_len;
   logic [2:0] jump_width;
   logic [4:0] sjw_e;
   logic sam_en;
   logic ps2_sel;

   // Edge and phase error
   logic fall_edge;
   logic sync_ok;
   logic [4:0] err_pos;
   logic [4:0] err_neg;

   // APB decode
   logic apb_done;
   logic apb_setup;
   logic [7:0] idx;
   logic idx_ok;
   logic [31:0] rd_val;

   logic restart;

   tq_divider u_div (
      .pclk (pclk),
      .presetn (presetn),
      .q (q)
   );

   assign q.prescale = r.cfg1[`CFG1_BRP_MSB:`CFG1_BRP_LSB];  // [R21]
   assign q.restart = restart;

   // Segment lengths; the adjustment registers hold only this bit's change
   always_comb begin
      sam_en = r.cfg2[`CFG2_SAM_BIT];
      ps2_sel = r.cfg2[`CFG2_SEL_BIT];
      prop_len = plus_one(r.cfg2[`CFG2_PROP_MSB:`CFG2_PROP_LSB]);  // [R2]
      ps1_nom = plus_one(r.cfg2[`CFG2_PS1_MSB:`CFG2_PS1_LSB]);  // [R3]
      ps1_len = ps1_nom + {1'b0, r.ext};  // [R12]
      if (ps2_sel) begin
         ps2_nom = plus_one(r.cfg3[`CFG3_PS2_MSB:`CFG3_PS2_LSB]);  // [R3]
      end else if (ps1_nom > `PROC_TIME_TQ) begin
         ps2_nom = ps1_nom;  // [R23]
      end else begin
         ps2_nom = `PROC_TIME_TQ;  // [R6] [R23]
      end
      ps2_len = ps2_nom - {1'b0, r.shorten};  // [R13]
      // A shortened second phase still covers the processing time
      if (ps2_len < `PROC_TIME_TQ) begin
         ps2_len = `PROC_TIME_TQ;  // [R6]
      end
      jump_width = {1'b0, r.cfg1[`CFG1_SJW_MSB:`CFG1_SJW_LSB]} + 3'h1;  // [R22]
      sjw_e = {2'b00, jump_width};  // [R14]
   end

   // Phase error in quanta: positive from the end of the sync segment, negative to the end of the second phase
   always_comb begin
      fall_edge = r.rx_prev & ~r.rx_q;  // [R15]
      // The previous sample must be recessive, the line now dominant
      sync_ok = fall_edge & ~r.synced & r.rx_bit;  // [R16] [R17]
      if (r.seg == SEG_PROP) begin
         err_pos = {1'b0, r.qcnt} + `ONE_E;  // [R10]
      end else begin
         err_pos = {1'b0, prop_len} + {1'b0, r.qcnt} + `ONE_E;  // [R10]
      end
      err_neg = {1'b0, ps2_len} - {1'b0, r.qcnt};  // [R10]
   end

   // APB decode; one wait state so every answer comes from a flop
   always_comb begin
      apb_setup = psel & penable & ~r.pready;
      apb_done = psel & penable & r.pready;
      idx = reg_index(paddr);
      idx_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0) &&
               ((idx == `IDX_CFG1) || (idx == `IDX_CFG2) ||
                (idx == `IDX_CFG3) || (idx == `IDX_STAT));
      rd_val = 32'h0000_0000;
      case (idx)
         `IDX_CFG1: rd_val[7:0] = r.cfg1;
         `IDX_CFG2: rd_val[7:0] = r.cfg2;
         `IDX_CFG3: rd_val[2:0] = r.cfg3;
         `IDX_STAT: rd_val[4:0] = {r.synced, r.seg, r.rx_q, r.rx_bit};
         default: rd_val = 32'h0000_0000;
      endcase
      if (!idx_ok) begin
         rd_val = 32'h0000_0000;
      end
   end

   // Next state of the whole core
   always_comb begin
      s = r;
      restart = 1'b0;
      s.bit_valid = 1'b0;
      s.bit_start = 1'b0;
      s.hard_sync = 1'b0;
      s.resync = 1'b0;

      // Bus slave: read data and error latched with the ready flop
      s.pready = apb_setup;
      if (apb_setup) begin
         s.prdata = pwrite ? 32'h0000_0000 : rd_val;
         s.pslverr = ~idx_ok;
      end
      if (apb_done && pwrite && idx_ok) begin
         case (idx)
            `IDX_CFG1: s.cfg1 = pwdata[7:0];
            `IDX_CFG2: s.cfg2 = pwdata[7:0];
            `IDX_CFG3: s.cfg3 = pwdata[2:0];
            default: s.cfg3 = r.cfg3;
         endcase
      end

      // Receive pin passes two flops before anything reads it
      s.rx_meta = rx_line;
      s.rx_q = r.rx_meta;
      s.rx_prev = r.rx_q;

      // Early samples one quantum and half a quantum before the end
      if (q.tq_tick || q.half_tick) begin
         s.samp_b = r.samp_a;  // [R5]
         s.samp_a = r.rx_q;  // [R5]
      end

      // Segment sequencing, one step per quantum
      if (q.tq_tick) begin
         case (r.seg)
            SEG_SYNC: begin
               s.seg = SEG_PROP;  // [R1] [R20]
               s.qcnt = 4'h0;
            end
            SEG_PROP: begin
               if (r.qcnt >= prop_len - `ONE_TQ) begin
                  s.seg = SEG_PH1;  // [R2] [R20]
                  s.qcnt = 4'h0;
               end else begin
                  s.qcnt = r.qcnt + 4'h1;
               end
            end
            SEG_PH1: begin
               if (r.qcnt >= ps1_len - `ONE_TQ) begin
                  // Sample point at the end of the first phase
                  if (sam_en) begin
                     s.rx_bit = vote(r.samp_a, r.samp_b, r.rx_q);  // [R5]
                  end else begin
                     s.rx_bit = r.rx_q;  // [R4]
                  end
                  s.bit_valid = 1'b1;  // [R24]
                  s.seg = SEG_PH2;  // [R20]
                  s.qcnt = 4'h0;
               end else begin
                  s.qcnt = r.qcnt + 4'h1;
               end
            end
            SEG_PH2: begin
               if (r.qcnt >= ps2_len - `ONE_TQ) begin
                  // New bit: drop this bit's adjustments
                  s.seg = SEG_SYNC;  // [R1] [R20]
                  s.qcnt = 4'h0;
                  s.ext = 3'h0;  // [R25]
                  s.shorten = 3'h0;  // [R25]
                  s.synced = 1'b0;  // [R16]
                  s.bit_start = 1'b1;
               end else begin
                  s.qcnt = r.qcnt + 4'h1;
               end
            end
            default: begin
               s.seg = SEG_SYNC;
               s.qcnt = 4'h0;
            end
         endcase
      end

      // Synchronisation overrides the step taken in the same cycle
      if (sync_ok) begin
         if (bus_idle) begin
            // Start of frame: restart the bit around this edge
            s.seg = SEG_SYNC;  // [R8]
            s.qcnt = 4'h0;
            s.ext = 3'h0;
            s.shorten = 3'h0;
            s.synced = 1'b1;  // [R9]
            s.hard_sync = 1'b1;
            s.bit_start = 1'b1;
            restart = 1'b1;  // [R8]
         end else begin
            case (r.seg)
               SEG_SYNC: begin
                  s.synced = 1'b1;  // [R10] [R16]
               end
               SEG_PROP, SEG_PH1: begin
                  // A transmitter keeps its own timing on late edges
                  if (!tx_active) begin  // [R18]
                     s.synced = 1'b1;  // [R16]
                     s.resync = 1'b1;
                     if (err_pos <= sjw_e) begin
                        s.seg = SEG_SYNC;  // [R11]
                        s.qcnt = 4'h0;
                        s.ext = 3'h0;
                        s.bit_start = 1'b1;
                        restart = 1'b1;  // [R11]
                     end else begin
                        s.ext = jump_width;  // [R12] [R14]
                     end
                  end
               end
               SEG_PH2: begin
                  s.synced = 1'b1;  // [R16]
                  s.resync = 1'b1;
                  if (err_neg <= sjw_e) begin
                     s.seg = SEG_SYNC;  // [R11]
                     s.qcnt = 4'h0;
                     s.shorten = 3'h0;
                     s.bit_start = 1'b1;
                     restart = 1'b1;  // [R11]
                  end else begin
                     s.shorten = jump_width;  // [R13] [R14]
                  end
               end
               default: begin
                  s.synced = r.synced;
               end
            endcase
         end
      end

      // A restart moves the sample point, so a sample due now is dropped
      if (restart) begin
         s.bit_valid = 1'b0;  // [R24]
         s.rx_bit = r.rx_bit;  // [R4]
      end
   end

   // Single state register; the line idles recessive out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.cfg1 <= `CFG1_RST;
         r.cfg2 <= `CFG2_RST;
         r.cfg3 <= `CFG3_RST;
         r.seg <= SEG_SYNC;
         r.rx_meta <= 1'b1;
         r.rx_q <= 1'b1;
         r.rx_prev <= 1'b1;
         r.samp_a <= 1'b1;
         r.samp_b <= 1'b1;
         r.rx_bit <= 1'b1;
      end else begin
         r <= s;
      end
   end

   // Every output straight from the state register
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign rx_bit = r.rx_bit;
   assign bit_valid = r.bit_valid;
   assign bit_start = r.bit_start;
   assign hard_sync = r.hard_sync;
   assign resync = r.resync;

endmodule

`default_nettype wire

// File: verif/can_bit_timing_sync_chk.sv
// Checker for the CAN bit timing block, bound to its top-level ports.
// Assumes one pclk domain with asynchronous active-low reset.
`default_nettype none

module can_bit_timing_sync_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_line,
   input wire logic bus_idle,
   input wire logic tx_active,
   input wire logic rx_bit,
   input wire logic bit_valid,
   input wire logic bit_start,
   input wire logic hard_sync,
   input wire logic resync
);
   // Longest bit is 25 quanta plus a 4 quanta jump, 128 cycles each
   localparam int BIT_MAX = 3712;
   logic [11:0] since_start_r;
   logic sync_ev;
   logic mapped;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Any synchronisation pulse, and the four decoded word addresses
   assign sync_ev = hard_sync || resync;
   assign mapped = paddr == 32'h0000_00A0 || paddr == 32'h0000_00A4 ||
                   paddr == 32'h0000_00A8 || paddr == 32'h0000_00AC;

   // Cycles since the last bit start, saturating so it cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_start_r <= 12'h000;
      end else if (bit_start) begin
         since_start_r <= 12'h000;
      end else if (since_start_r != 12'hFFF) begin
         since_start_r <= since_start_r + 12'h001;
      end
   end

   sequence req_wait;
      psel && penable && !pready;
   endsequence

   a_valid_pulse: assert property (bit_valid |=> !bit_valid)
      else $error("bit_valid longer than one cycle");
   a_start_valid_apart: assert property (!(bit_start && bit_valid))
      else $error("bit start and sample point coincide");
   a_ready_wait: assert property (req_wait |=> pready)
      else $error("pready not given after one wait state");
   a_ready_in_access: assert property
      (pready |-> psel && penable && $past(psel && penable))
      else $error("pready outside an access phase");
   a_err_unmapped: assert property
      (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_hard_restart: assert property (hard_sync |-> bit_start && !resync)
      else $error("hard sync did not restart the bit");
   a_one_sync: assert property (sync_ev |=> !sync_ev until bit_start)
      else $error("second synchronisation in one bit");
   a_bit_bounded: assert property (since_start_r <= BIT_MAX)
      else $error("bit time exceeds its longest length");
   a_ps2_floor: assert property
      (bit_valid |=> (!bit_start || sync_ev) [*3])
      else $error("second phase shorter than processing time");
   a_rx_held: assert property (!bit_valid |-> $stable(rx_bit))
      else $error("rx_bit changed away from the sample point");
endmodule

bind can_bit_timing_sync can_bit_timing_sync_chk can_bit_timing_sync_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
   .bus_idle(bus_idle), .tx_active(tx_active), .rx_bit(rx_bit),
   .bit_valid(bit_valid), .bit_start(bit_start), .hard_sync(hard_sync),
   .resync(resync));

`default_nettype wire

// File: verif/can_node_model.sv
// Remote CAN node: sends a 16-bit frame MSB first at a set bit length.
// Assumes the bus rests recessive (1) between frames, as its bias does.
`default_nettype none

module can_node_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [15:0] frame,
   input wire logic [7:0] bit_cycles,
   output logic rx_line,
   output logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] shift_r;
   logic [4:0] left_r;
   logic [7:0] cnt_r;

   // Bit length differs from the receiver's to force phase errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r <= 16'hFFFF;
         left_r <= 5'h00;
         cnt_r <= 8'h00;
      end else if (start && left_r == 5'h00) begin
         shift_r <= frame;
         left_r <= 5'h10;
         cnt_r <= bit_cycles - 8'h01;
      end else if (left_r != 5'h00) begin
         if (cnt_r == 8'h00) begin
            shift_r <= {shift_r[14:0], 1'b1};
            left_r <= left_r - 5'h01;
            cnt_r <= bit_cycles - 8'h01;
         end else begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end

   // Released line returns to recessive
   assign rx_line = (left_r != 5'h00) ? shift_r[15] : 1'b1;
   assign busy = left_r != 5'h00;
endmodule

`default_nettype wire

// File: verif/can_bit_timing_sync_test.sv
// Self-checking bench for the CAN bit timing block.
// Assumes the design, its checker and the remote node model compiled.
`default_nettype none

module can_bit_timing_sync_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic rx_line, bus_idle, tx_active, rx_bit, bit_valid, bit_start;
   logic hard_sync, resync, start, busy;
   logic [15:0] frame;
   logic [7:0] bit_cycles;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;

   can_bit_timing_sync can_bit_timing_sync_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_line(rx_line), .bus_idle(bus_idle),
      .tx_active(tx_active), .rx_bit(rx_bit), .bit_valid(bit_valid),
      .bit_start(bit_start), .hard_sync(hard_sync), .resync(resync));
   can_node_model can_node_model_inst (.pclk(pclk), .presetn(presetn),
      .start(start), .frame(frame), .bit_cycles(bit_cycles),
      .rx_line(rx_line), .busy(busy));

   always #2 pclk = ~pclk;

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic cfg(input logic [7:0] c1, c2, c3);
      logic [31:0] q;
      logic e;
      apb(1'b1, 32'h0000_00A8, {24'h00_0000, c1}, q, e);
      apb(1'b1, 32'h0000_00A4, {24'h00_0000, c2}, q, e);
      apb(1'b1, 32'h0000_00A0, {24'h00_0000, c3}, q, e);
   endtask

   // Cycles until bit_valid (sel 0) or bit_start (sel 1) is seen
   task automatic gap(input logic sel, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((sel ? bit_start : bit_valid) !== 1'b1);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      logic e;
      logic [31:0] mask [3] = '{32'h0000_0007, 32'h0000_00FF, 32'h0000_00FF};
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 32'h0000_00A0 + 4 * i, 32'h0, q, e);
         chk("cfg reset", 32'h0, q);
         apb(1'b1, 32'h0000_00A0 + 4 * i, 32'hFFFF_FFFF, q, e);
         apb(1'b0, 32'h0000_00A0 + 4 * i, 32'h0, q, e);
         chk("cfg readback", mask[i], q);
         chk("cfg error", 32'h0, {31'h0, e});
      end
      apb(1'b0, 32'h0000_00B0, 32'h0, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      apb(1'b1, 32'h0000_00AC, 32'h0000_00FF, q, e);
      chk("status write error", 32'h0, {31'h0, e});
   endtask

   // Segment lengths worked out from the fields, then measured
   task automatic t_timing(input logic [7:0] c1, c2, c3);
      int q, pr, p1, p2, n, m;
      q = 2 * (c1[5:0] + 1);
      pr = c2[2:0] + 1;
      p1 = c2[5:3] + 1;
      p2 = c2[7] ? c3[2:0] + 1 : (p1 > 2 ? p1 : 2);
      cfg(c1, c2, c3);
      repeat (2) gap(1'b1, n);
      gap(1'b0, n);
      gap(1'b1, m);
      chk("start to sample", (1 + pr + p1) * q, n);
      chk("sample to start", p2 * q, m);
   endtask

   // Frame from the remote node: hard sync, then resync on falling edges
   task automatic t_frame(input logic [7:0] c1, input logic triple_sample_enable, tx,
                          input logic [7:0] cyc);
      logic [15:0] got;
      int rs, rp, i;
      logic pre;
      // Second phase of four quanta leaves room for a full jump width
      cfg(c1, {1'b1, triple_sample_enable, 6'b010_001}, 8'h03);
      tx_active <= tx;
      bus_idle <= 1'b1;
      frame <= 16'h4D26;
      bit_cycles <= cyc;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      i = 0;
      while (hard_sync !== 1'b1 && i < 100) begin
         @(posedge pclk);
         i++;
      end
      chk("hard sync", 32'h1, {31'h0, hard_sync});
      bus_idle <= 1'b0;
      rs = 0;
      rp = 0;
      pre = 1'b1;
      i = 0;
      while (i < 16) begin
         @(posedge pclk);
         rs += (resync === 1'b1);
         // Only a resync between bit start and sample is a late edge
         rp += (resync === 1'b1 && pre);
         if (bit_start === 1'b1) pre = 1'b1;
         if (bit_valid === 1'b1) begin
            pre = 1'b0;
            got = {got[14:0], rx_bit};
            i++;
         end
      end
      if (tx) chk("resync while sending", 32'h0, rp);
      else chk("bits", 32'h4D26, {16'h0, got});
      if (!tx) chk("resync used", 32'h1, {31'h0, rs > 0});
      while (busy) @(posedge pclk);
      repeat (40) @(posedge pclk);
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      bus_idle = 1'b1;
      tx_active = 1'b0;
      start = 1'b0;
      frame = 16'hFFFF;
      bit_cycles = 8'h13;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_timing(8'h00, 8'h00, 8'h00);
      t_timing(8'h01, 8'h91, 8'h03);
      t_timing(8'h00, 8'h18, 8'h00);
      t_timing(8'h3F, 8'h07, 8'h00);
      t_timing(8'h00, 8'hBF, 8'h07);
      t_frame(8'h00, 1'b0, 1'b0, 8'h15);
      t_frame(8'h40, 1'b1, 1'b0, 8'h13);
      t_frame(8'h40, 1'b0, 1'b1, 8'h15);
      print_verdict();
   end
endmodule

`default_nettype wire
